// ===== inc/pwmcs_pkg.sv
// constants for the two-channel pwm clock/counter/period core
// assumes one aclk domain and an axi4-lite register port
package pwmcs_pkg;
	// ----------------------------------------------------------------
	// register indices; byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CTRL     = 8'h60;
	localparam logic [7:0] IDX_PRESCALE = 8'h61;
	localparam logic [7:0] IDX_SCALE_A  = 8'h62;
	localparam logic [7:0] IDX_SCALE_B  = 8'h63;
	localparam logic [7:0] IDX_CNT0     = 8'h64;
	localparam logic [7:0] IDX_CNT1     = 8'h65;
	localparam logic [7:0] IDX_PER0     = 8'h66;
	localparam logic [7:0] IDX_PER1     = 8'h67;
	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int         EN_LSB       = 0;
	localparam int         POL_LSB      = 2;
	localparam int         CLKSEL_LSB   = 4;
	localparam int         CAE_LSB      = 6;
	localparam int         PCKA_LSB     = 0;
	localparam int         PCKB_LSB     = 4;
	localparam logic [7:0] PRESCALE_MASK = 8'h77;
	localparam logic [7:0] REG_RESET    = 8'h00;
	localparam int         PRE_W        = 7;
	localparam logic [1:0] RESP_OKAY    = 2'b00;
	localparam logic [1:0] RESP_SLVERR  = 2'b10;
endpackage : pwmcs_pkg

// ===== core/pwmcs_core.sv
// pwm timing core: prescalers, scalers, channel counters, period latches
// assumes aclk is the die interface clock and software uses axi4-lite
//
// What this block does
// - clock B divides by two to code
// - clock A divides by two to code
// - SA is A over twice scale, 0=256
// - SB is B over twice scale, 0=256
// - scale write reloads scale down counter now
// - align bit set means center aligned
// - clock select applies at once, any time
// - each channel has 8-bit up/down counter
// - counter read never disturbs counting
// - left aligned counts 0 to period-1
// - center counts 0 up to period, down
// - counter write clears, up, loads period
// - counter cleared at end of period
// - disabled counter holds, resumes from value
// - enabled period writes wait for boundary
// - disabled period write updates latch too
// - period read returns buffer value
// - period is clock times period or twice
// - select bit picks prescaled or scaled clock
// - reserved bits read zero, ignore writes
// - scaler: 8-bit down count, pulse, halve
`timescale 1ns/1ps
module pwmcs_core #(
	parameter int AW = 12
) (
	// clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// axi4-lite write
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	// axi4-lite read
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	// channel state toward the output logic
	output logic [7:0]         chan0_count,
	output logic [7:0]         chan1_count,
	output logic [7:0]         chan0_period_active,
	output logic [7:0]         chan1_period_active,
	output logic [1:0]         chan_count_down,
	output logic [1:0]         chan_enable,
	output logic [1:0]         chan_polarity,
	output logic [1:0]         chan_center,
	output logic [1:0]         chan_tick_q
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic          aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [AW-1:0] aw_addr_q, aw_addr_d;
	logic [7:0]    w_data_q, w_data_d;
	logic          w_lane_q, w_lane_d;
	logic          bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]    bresp_q, bresp_d, rresp_q, rresp_d;
	logic [7:0]    rdata_q, rdata_d;
	logic [7:0]    ctl_q, ctl_d, prs_q, prs_d;
	logic [7:0]    scl_q [2];
	logic [7:0]    scl_d [2];
	logic [7:0]    sc_q [2];
	logic [7:0]    sc_d [2];
	logic [1:0]    half_q, half_d;
	logic [pwmcs_pkg::PRE_W-1:0] pre_q, pre_d;
	logic [7:0]    cnt_q [2];
	logic [7:0]    cnt_d [2];
	logic [7:0]    perbuf_q [2];
	logic [7:0]    perbuf_d [2];
	logic [7:0]    per_q [2];
	logic [7:0]    per_d [2];
	logic [1:0]    down_q, down_d, tick_q, tick_d;

	logic          wr_fire, wr_hit;
	logic [7:0]    wr_idx;
	logic [1:0]    scl_wr, cnt_wr, per_wr, ptick, stick, ctick, en;
	logic [7:0]    rd_idx;

	function automatic logic [7:0] reg_index(input logic [AW-1:0] addr);
		reg_index = (addr[AW-1:10] == '0) ? addr[9:2] : 8'hff;
	endfunction : reg_index

	function automatic logic is_mapped(input logic [7:0] idx);
		is_mapped = (idx >= pwmcs_pkg::IDX_CTRL) && (idx <= pwmcs_pkg::IDX_PER1);
	endfunction : is_mapped

	// one tick in 2^code cycles of the prescale count, which runs while either channel is on
	function automatic logic pre_tick(input logic [2:0] code,
			input logic [pwmcs_pkg::PRE_W-1:0] c);
		logic [pwmcs_pkg::PRE_W-1:0] mask;
		mask = (pwmcs_pkg::PRE_W)'((8'h01 << code) - 8'h01);
		pre_tick = ((c & mask) == mask);
	endfunction : pre_tick

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	// address and data are captured independently; the write commits one
	// cycle after both are held, so bvalid rises one edge after the later one
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready  = !w_hold_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = {24'h00_0000, rdata_q};

	assign wr_fire = aw_hold_q && w_hold_q;
	assign wr_idx  = reg_index(aw_addr_q);
	assign wr_hit  = wr_fire && w_lane_q && is_mapped(wr_idx);
	assign scl_wr  = {wr_hit && wr_idx == pwmcs_pkg::IDX_SCALE_B,
		wr_hit && wr_idx == pwmcs_pkg::IDX_SCALE_A};
	assign cnt_wr  = {wr_hit && wr_idx == pwmcs_pkg::IDX_CNT1,
		wr_hit && wr_idx == pwmcs_pkg::IDX_CNT0};
	assign per_wr  = {wr_hit && wr_idx == pwmcs_pkg::IDX_PER1,
		wr_hit && wr_idx == pwmcs_pkg::IDX_PER0};
	assign rd_idx  = reg_index(s_axi_araddr);

	always_comb begin
		aw_hold_d = aw_hold_q;
		aw_addr_d = aw_addr_q;
		w_hold_d  = w_hold_q;
		w_data_d  = w_data_q;
		w_lane_d  = w_lane_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_d = 1'b1;
			w_data_d = s_axi_wdata[7:0];
			w_lane_d = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_hold_d = 1'b0;
			w_hold_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = is_mapped(wr_idx) ? pwmcs_pkg::RESP_OKAY : pwmcs_pkg::RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d  = pwmcs_pkg::RESP_OKAY;
			// reads are side-effect free: counters keep running
			if (rd_idx == pwmcs_pkg::IDX_CTRL) begin
				rdata_d = ctl_q;
			end else if (rd_idx == pwmcs_pkg::IDX_PRESCALE) begin
				rdata_d = prs_q;
			end else if (rd_idx == pwmcs_pkg::IDX_SCALE_A) begin
				rdata_d = scl_q[0];
			end else if (rd_idx == pwmcs_pkg::IDX_SCALE_B) begin
				rdata_d = scl_q[1];
			end else if (rd_idx == pwmcs_pkg::IDX_CNT0) begin
				rdata_d = cnt_q[0];
			end else if (rd_idx == pwmcs_pkg::IDX_CNT1) begin
				rdata_d = cnt_q[1];
			end else if (rd_idx == pwmcs_pkg::IDX_PER0) begin
				rdata_d = perbuf_q[0];
			end else if (rd_idx == pwmcs_pkg::IDX_PER1) begin
				rdata_d = perbuf_q[1];
			end else begin
				rdata_d = 8'h00;
				rresp_d = pwmcs_pkg::RESP_SLVERR;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			aw_addr_q <= '0;
			w_hold_q  <= 1'b0;
			w_data_q  <= 8'h00;
			w_lane_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= pwmcs_pkg::RESP_OKAY;
			rvalid_q  <= 1'b0;
			rresp_q   <= pwmcs_pkg::RESP_OKAY;
			rdata_q   <= 8'h00;
		end else begin
			aw_hold_q <= aw_hold_d;
			aw_addr_q <= aw_addr_d;
			w_hold_q  <= w_hold_d;
			w_data_q  <= w_data_d;
			w_lane_q  <= w_lane_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// control, prescaler and scalers
	// ----------------------------------------------------------------
	assign en = ctl_q[pwmcs_pkg::EN_LSB +: 2];
	// prescale count stops while both channels are off, to save power
	assign ptick[0] = (|en) && pre_tick(prs_q[pwmcs_pkg::PCKA_LSB +: 3], pre_q);
	assign ptick[1] = (|en) && pre_tick(prs_q[pwmcs_pkg::PCKB_LSB +: 3], pre_q);

	always_comb begin
		ctl_d  = ctl_q;
		prs_d  = prs_q;
		pre_d  = pre_q;
		half_d = half_q;
		stick  = 2'b00;
		if (wr_hit && wr_idx == pwmcs_pkg::IDX_CTRL) begin
			ctl_d = w_data_q;
		end
		if (wr_hit && wr_idx == pwmcs_pkg::IDX_PRESCALE) begin
			prs_d = w_data_q & pwmcs_pkg::PRESCALE_MASK;
		end
		if (|en) begin
			pre_d = pre_q + 1'b1;
		end
		for (int j = 0; j < 2; j++) begin
			scl_d[j] = scl_wr[j] ? w_data_q : scl_q[j];
			sc_d[j]  = sc_q[j];
			if (scl_wr[j]) begin
				sc_d[j] = w_data_q;
			end else if (ptick[j]) begin
				// a loaded zero wraps through 255, giving 256 ticks
				if (sc_q[j] == 8'h01) begin
					sc_d[j]   = scl_q[j];
					half_d[j] = !half_q[j];
					stick[j]  = half_q[j];
				end else begin
					sc_d[j] = sc_q[j] - 8'h01;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_q  <= pwmcs_pkg::REG_RESET;
			prs_q  <= pwmcs_pkg::REG_RESET;
			pre_q  <= '0;
			half_q <= 2'b00;
			for (int j = 0; j < 2; j++) begin
				scl_q[j] <= pwmcs_pkg::REG_RESET;
				sc_q[j]  <= pwmcs_pkg::REG_RESET;
			end
		end else begin
			ctl_q  <= ctl_d;
			prs_q  <= prs_d;
			pre_q  <= pre_d;
			half_q <= half_d;
			for (int j = 0; j < 2; j++) begin
				scl_q[j] <= scl_d[j];
				sc_q[j]  <= sc_d[j];
			end
		end
	end

	// ----------------------------------------------------------------
	// channel counters and period latches
	// ----------------------------------------------------------------
	// channel 0 takes A or SA, channel 1 takes B or SB
	assign ctick = en & ((ctl_q[pwmcs_pkg::CLKSEL_LSB +: 2] & stick)
		| (~ctl_q[pwmcs_pkg::CLKSEL_LSB +: 2] & ptick));

	// align bits are assumed stable while enabled
	always_comb begin
		down_d = down_q;
		tick_d = ctick;
		for (int i = 0; i < 2; i++) begin
			perbuf_d[i] = per_wr[i] ? w_data_q : perbuf_q[i];
			per_d[i]    = per_q[i];
			cnt_d[i]    = cnt_q[i];
			if (cnt_wr[i]) begin
				cnt_d[i]  = 8'h00;
				down_d[i] = 1'b0;
				per_d[i]  = perbuf_d[i];
			end else if (!en[i]) begin
				per_d[i] = perbuf_d[i];
			end else if (ctick[i]) begin
				if (!ctl_q[pwmcs_pkg::CAE_LSB + i]) begin
					if (per_q[i] == 8'h00 || cnt_q[i] >= per_q[i] - 8'h01) begin
						cnt_d[i] = 8'h00;
						per_d[i] = perbuf_d[i];
					end else begin
						cnt_d[i] = cnt_q[i] + 8'h01;
					end
				end else if (!down_q[i]) begin
					if (cnt_q[i] >= per_q[i]) begin
						down_d[i] = (per_q[i] != 8'h00);
						cnt_d[i]  = (per_q[i] == 8'h00) ? 8'h00 : cnt_q[i] - 8'h01;
					end else begin
						cnt_d[i] = cnt_q[i] + 8'h01;
					end
				end else if (cnt_q[i] <= 8'h01) begin
					cnt_d[i]  = 8'h00;
					down_d[i] = 1'b0;
					per_d[i]  = perbuf_d[i];
				end else begin
					cnt_d[i] = cnt_q[i] - 8'h01;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			down_q <= 2'b00;
			tick_q <= 2'b00;
			for (int i = 0; i < 2; i++) begin
				cnt_q[i]    <= pwmcs_pkg::REG_RESET;
				perbuf_q[i] <= pwmcs_pkg::REG_RESET;
				per_q[i]    <= pwmcs_pkg::REG_RESET;
			end
		end else begin
			down_q <= down_d;
			tick_q <= tick_d;
			for (int i = 0; i < 2; i++) begin
				cnt_q[i]    <= cnt_d[i];
				perbuf_q[i] <= perbuf_d[i];
				per_q[i]    <= per_d[i];
			end
		end
	end

	assign chan0_count         = cnt_q[0];
	assign chan1_count         = cnt_q[1];
	assign chan0_period_active = per_q[0];
	assign chan1_period_active = per_q[1];
	assign chan_count_down     = down_q;
	assign chan_enable         = en;
	assign chan_polarity       = ctl_q[pwmcs_pkg::POL_LSB +: 2];
	assign chan_center         = ctl_q[pwmcs_pkg::CAE_LSB +: 2];
	assign chan_tick_q         = tick_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_cnt_write_clear: assert property (cnt_wr[0] |=> cnt_q[0] == 8'h00 && !down_q[0]
		&& per_q[0] == $past(perbuf_d[0])) else $error("counter write not cleared");
	chk_hold_disabled: assert property (!en[1] && !cnt_wr[1] |=> cnt_q[1] == $past(cnt_q[1]))
		else $error("disabled counter moved");
	chk_left_bound: assert property (en[0] && !chan_center[0] && per_q[0] != 8'h00
		&& $stable(per_q[0]) && $past(en[0]) && $past(!chan_center[0]) |-> cnt_q[0] < per_q[0]
		|| $past(cnt_q[0]) >= per_q[0]) else $error("left count past period");
	chk_center_turn: assert property (en[0] && chan_center[0] && !down_q[0] && ctick[0]
		&& cnt_q[0] == per_q[0] && per_q[0] > 8'h01 && !cnt_wr[0] |=> down_q[0])
		else $error("center count did not turn");
	chk_latch_disabled: assert property (!en[0] && $past(!en[0]) |-> per_q[0] == perbuf_q[0])
		else $error("disabled latch not following buffer");
	chk_latch_buffered: assert property (en[0] && $past(en[0]) && !$past(cnt_wr[0])
		&& !$past(ctick[0]) |-> $stable(per_q[0])) else $error("latch changed mid period");
	chk_scale_reload: assert property (scl_wr[0] |=> sc_q[0] == $past(w_data_q))
		else $error("scale counter not reloaded");
	chk_prescale_half: assert property (ptick[1] && prs_q[6:4] == 3'd1 && $stable(prs_q)
		|=> !ptick[1]) else $error("clock B divide by two broken");
	chk_prescale_a: assert property (ptick[0] && prs_q[2:0] == 3'd2 && $stable(prs_q)
		|=> !ptick[0] [*3]) else $error("clock A divide by four broken");
	chk_scaled_from_a: assert property (stick[0] |-> ptick[0] && sc_q[0] == 8'h01)
		else $error("SA pulse without A tick");
	chk_reserved_zero: assert property (prs_q[7] == 1'b0 && prs_q[3] == 1'b0)
		else $error("reserved prescale bit set");

	cov_left_wrap: cover property (en[0] && !chan_center[0] && ctick[0] ##1 cnt_q[0] == 8'h00);
	cov_center_down: cover property (en[1] && down_q[1] ##1 !down_q[1]);
	cov_sb_tick: cover property (stick[1] && en[1]);
	cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == pwmcs_pkg::RESP_SLVERR);
endmodule : pwmcs_core

// ===== dv/pwmcs_drive_model.sv
// stand-in for the on-die high-side and low-side output drivers
// assumes channel state arrives straight from pwmcs_core in the aclk domain
`timescale 1ns/1ps
module pwmcs_drive_model (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// channel state from the timing core
	input  wire logic [7:0] chan0_count,
	input  wire logic [7:0] chan1_count,
	input  wire logic [7:0] chan0_period_active,
	input  wire logic [7:0] chan1_period_active,
	input  wire logic [1:0] chan_enable,
	input  wire logic [1:0] chan_polarity,
	// driver gate levels
	output logic [1:0]      drive_q
);
	// ----------------------------------------------------------------
	// half-period compare, since duty logic lives outside the core
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drive_q <= 2'b00;
		end else begin
			drive_q[0] <= chan_enable[0] & (chan_polarity[0] ^ (chan0_count >= chan0_period_active >> 1));
			drive_q[1] <= chan_enable[1] & (chan_polarity[1] ^ (chan1_count >= chan1_period_active >> 1));
		end
	end
endmodule : pwmcs_drive_model

// ===== dv/testbench.sv
// random clock setups and corner cases for pwmcs_core over axi4-lite
// assumes pwmcs_pkg and the driver model are compiled first
`timescale 1ns/1ps
module testbench;
	logic        aclk, aresetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  chan0_count, chan1_count, chan0_period_active, chan1_period_active;
	logic [1:0]  chan_enable, chan_polarity, drive_q;
	logic [1:0]  chan_center, chan_tick_q, chan_count_down;
	logic [7:0]  rd, rd2;
	logic [1:0]  rs, bs;
	int          error_cnt, samples_checked, i, ch, code, sel, scl, p, n, m, dn;

	pwmcs_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan0_count,
		.chan1_count, .chan0_period_active, .chan1_period_active, .chan_count_down,
		.chan_enable, .chan_polarity, .chan_center, .chan_tick_q);
	pwmcs_drive_model drv (.aclk, .aresetn, .chan0_count, .chan1_count,
		.chan0_period_active, .chan1_period_active, .chan_enable, .chan_polarity, .drive_q);

	always #5 aclk = ~aclk;
	// ----------------------------------------------------------------
	// reporting and compares
	// ----------------------------------------------------------------
	task automatic summarize;
		$display("mismatches %0d, compares %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	task automatic fail(input string msg);
		error_cnt++;
		$display("unexpected at %0t: %s", $time, msg);
	endtask : fail
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string msg);
		samples_checked++;
		if (got !== exp)
			fail(msg);
	endtask : chk_val
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string msg);
		samples_checked++;
		if (got !== exp)
			fail(msg);
	endtask : chk_resp
	task automatic chk_cyc(input int got, input int exp, input string msg);
		samples_checked++;
		if (got != exp)
			fail(msg);
	endtask : chk_cyc
	function automatic int exp_gap(input int c, input int s, input int v);
		return (1 << c) * (s ? 2 * (v == 0 ? 256 : v) : 1);
	endfunction : exp_gap
	// ----------------------------------------------------------------
	// axi4-lite master
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		int k;
		bit a, w;
		a = 0;
		w = 0;
		@(posedge aclk);
		s_axi_awaddr  <= {2'b00, idx, 2'b00};
		s_axi_wdata   <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (k = 0; k < 64; k++) begin
			@(posedge aclk);
			if (a && w && s_axi_bvalid) begin
				bs = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
			if (!a && s_axi_awready) begin
				a = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		if (k == 64) begin
			fail("write response missing");
			summarize();
		end
	endtask : wr
	task automatic rdr(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] r);
		int k;
		@(posedge aclk);
		s_axi_araddr  <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (k = 0; k < 64; k++) begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata[7:0];
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (k == 64) begin
			fail("read data missing");
			summarize();
		end
	endtask : rdr
	// ----------------------------------------------------------------
	// port observers
	// ----------------------------------------------------------------
	// spacing of the third count step; the first ones may be irregular
	task automatic gap(input int c, output int g);
		logic [7:0] v;
		int k, s;
		s = 0;
		g = 0;
		v = c ? chan1_count : chan0_count;
		for (k = 0; k < 20000 && s < 3; k++) begin
			@(posedge aclk);
			if (s == 2)
				g++;
			if ((c ? chan1_count : chan0_count) !== v) begin
				s++;
				v = c ? chan1_count : chan0_count;
			end
		end
		if (s < 3) begin
			fail("channel counter stalled");
			summarize();
		end
	endtask : gap
	// cycles between two returns to zero and the top count in between
	task automatic span(output int len, output int top, output int dn);
		logic [7:0] v, prev;
		int k, z;
		z = 0;
		len = 0;
		top = 0;
		dn = 0;
		prev = chan0_count;
		for (k = 0; k < 5000 && z < 2; k++) begin
			@(posedge aclk);
			v = chan0_count;
			if (z == 1)
				len++;
			if (z == 1 && v > top)
				top = v;
			if (z == 1 && chan_count_down[0])
				dn++;
			if (v == 8'h00 && prev != 8'h00)
				z++;
			prev = v;
		end
		if (z < 2) begin
			fail("counter never wrapped");
			summarize();
		end
	endtask : span
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		error_cnt = 0;
		samples_checked = 0;
		void'($urandom(32'h2116));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 8; i++) begin
			rdr(8'h60 + i[7:0], rd, rs);
			chk_val(rd, pwmcs_pkg::REG_RESET, "register not zero after reset");
		end
		rdr(8'h70, rd, rs);
		chk_resp(rs, pwmcs_pkg::RESP_SLVERR, "unmapped read accepted");
		chk_val(rd, 8'h00, "unmapped read data");
		wr(8'h70, 8'h5A);
		chk_resp(bs, pwmcs_pkg::RESP_SLVERR, "unmapped write accepted");
		wr(pwmcs_pkg::IDX_PRESCALE, 8'hFF);
		rdr(pwmcs_pkg::IDX_PRESCALE, rd, rs);
		chk_val(rd, pwmcs_pkg::PRESCALE_MASK, "prescale spare bits");
		// lane 0 strobe low: answered but dropped
		s_axi_wstrb <= 4'hE;
		wr(pwmcs_pkg::IDX_PER1, 8'h33);
		s_axi_wstrb <= 4'hF;
		rdr(pwmcs_pkg::IDX_PER1, rd, rs);
		chk_val(rd, pwmcs_pkg::REG_RESET, "masked write landed");
		wr(pwmcs_pkg::IDX_PER0, 8'h2A);
		chk_resp(bs, pwmcs_pkg::RESP_OKAY, "mapped write refused");
		@(posedge aclk);
		chk_val(chan0_period_active, 8'h2A, "idle period latch");
		// random clock setups; corners first: scale 256, divide 128, 4, 2
		for (i = 0; i < 8; i++) begin
			ch = $urandom_range(1, 0);
			code = (i == 1) ? 7 : (i == 2) ? 2 : (i == 3) ? 1 : $urandom_range(3, 0);
			sel = (i == 0) ? 1 : (i == 1) ? 0 : $urandom_range(1, 0);
			scl = (i == 0) ? 0 : $urandom_range(3, 0);
			wr(pwmcs_pkg::IDX_PRESCALE, {1'b0, code[2:0], 1'b0, code[2:0]});
			wr(pwmcs_pkg::IDX_SCALE_A, scl[7:0]);
			wr(pwmcs_pkg::IDX_SCALE_B, scl[7:0]);
			wr(pwmcs_pkg::IDX_PER0 + ch[7:0], 8'hC8);
			wr(pwmcs_pkg::IDX_CTRL, 8'(1 << ch) | 8'(sel << (4 + ch)));
			gap(ch, n);
			chk_cyc(n, exp_gap(code, sel, scl), "spacing");
			wr(pwmcs_pkg::IDX_CTRL, 8'h00);
			rdr(pwmcs_pkg::IDX_CNT0 + ch[7:0], rd, rs);
			repeat (20) @(posedge aclk);
			rdr(pwmcs_pkg::IDX_CNT0 + ch[7:0], rd2, rs);
			chk_val(rd2, rd, "disabled counter moved");
		end
		// left then center shapes on channel 0
		for (i = 0; i < 4; i++) begin
			p = $urandom_range(12, 3);
			wr(pwmcs_pkg::IDX_PRESCALE, 8'h00);
			wr(pwmcs_pkg::IDX_CTRL, {1'b0, i[1], 6'h00});
			wr(pwmcs_pkg::IDX_PER0, p[7:0]);
			wr(pwmcs_pkg::IDX_CTRL, {1'b0, i[1], 6'h01});
			span(n, m, dn);
			chk_cyc(n, i[1] ? 2 * p : p, "period length");
			chk_cyc(m, i[1] ? p : p - 1, "top of count");
			chk_cyc(dn, i[1] ? p - 1 : 0, "down count cycles");
			chk_val({6'h00, chan_center}, {6'h00, 1'b0, i[1]}, "align bit");
			chk_val({6'h00, chan_tick_q}, 8'h01, "clock A enable pulse");
			// disable first, keeping the align bit as it is
			wr(pwmcs_pkg::IDX_CTRL, {1'b0, i[1], 6'h00});
		end
		wr(pwmcs_pkg::IDX_CTRL, 8'h00);
		// period change while running waits for the counter write or the period end
		wr(pwmcs_pkg::IDX_PER0, 8'hC8);
		wr(pwmcs_pkg::IDX_CTRL, 8'h05);
		wr(pwmcs_pkg::IDX_CNT0, 8'h55);
		wr(pwmcs_pkg::IDX_PER0, 8'h05);
		@(posedge aclk);
		chk_val(chan0_period_active, 8'hC8, "running period not buffered");
		rdr(pwmcs_pkg::IDX_PER0, rd, rs);
		chk_val(rd, 8'h05, "period read not buffer");
		wr(pwmcs_pkg::IDX_CNT0, 8'h00);
		@(posedge aclk);
		chk_val(chan0_period_active, 8'h05, "counter write did not load period");
		chk_val({6'h00, chan_polarity}, 8'h01, "polarity bit");
		chk_val({6'h00, drive_q}, 8'h01, "driver start level");
		wr(pwmcs_pkg::IDX_PER0, 8'h07);
		repeat (8) @(posedge aclk);
		chk_val(chan0_period_active, 8'h07, "period end did not load buffer");
		summarize();
	end
endmodule : testbench
